// [hw/dcq_params.svh]
// Register map, field positions, reset values and codes for the CRC unit
`ifndef DCQ_PARAMS_SVH
`define DCQ_PARAMS_SVH

// Register indices; byte address is four times the index
`define DCQ_IDX_CTRL 8'h00
`define DCQ_IDX_CRCCTRL 8'h02
`define DCQ_IDX_DATAIN 8'h04
`define DCQ_IDX_CHKSUM 8'h08
`define DCQ_IDX_STATUS 8'h0c
`define DCQ_IDX_DBG 8'h0d
`define DCQ_IDX_QOS 8'h0e

// Control register fields
`define DCQ_CTRL_SWRST 0
`define DCQ_CTRL_ON 2

// Checksum control fields
`define DCQ_CC_BEAT_LSB 0
`define DCQ_CC_POLY_LSB 2
`define DCQ_CC_SRC_LSB 8

// Status fields
`define DCQ_ST_BUSY 0
`define DCQ_ST_ZERO 1

// Debug control field
`define DCQ_DBG_RUN 0

// Priority field positions
`define DCQ_QOS_WRB_LSB 0
`define DCQ_QOS_FETCH_LSB 2
`define DCQ_QOS_XFER_LSB 4

// Reset values
`define DCQ_RST_CHKSUM 32'h00000000
`define DCQ_RST_QOS 6'h2a

// Source select codes
`define DCQ_SRC_NONE 6'h00
`define DCQ_SRC_IO 6'h01
`define DCQ_SRC_CHAN 6'h20

// Polynomial codes and generators
`define DCQ_POLY_CRC16 2'h0
`define DCQ_POLY_CRC32 2'h1
`define DCQ_GEN16 16'h1021
`define DCQ_GEN32 32'h04c11db7

// Beat size codes
`define DCQ_BEAT_BYTE 2'h0
`define DCQ_BEAT_HWORD 2'h1
`define DCQ_BEAT_WORD 2'h2

`endif

// [hw/dcq_pkg.sv]
// Types shared by the CRC unit and its test bench
package dcq_pkg;

	// Input feed sequencer, one-hot
	typedef enum logic [1:0] {
		FEED_IDLE = 2'b01,
		FEED_WAIT = 2'b10
	} dcq_feed_type;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [9:0] paddr;
		logic [31:0] pwdata;
	} dcq_apb_req_type;

	// Beat moved by a channel of the transfer engine
	typedef struct packed {
		logic valid;
		logic [4:0] channel;
		logic [1:0] beatCode;
		logic [31:0] data;
	} dcq_beat_type;

	// Memory priority levels for the three access kinds
	typedef struct packed {
		logic [1:0] transferPriority;
		logic [1:0] fetchPriority;
		logic [1:0] writebackPriority;
	} dcq_qos_type;

	// Whole state of the unit
	typedef struct packed {
		logic checksumUnitOn;
		logic checksumInProgress;
		logic resultIsZeroFlag;
		logic [5:0] checksumSourceSelect;
		logic [1:0] polynomialSelect;
		logic [1:0] beatSizeCode;
		logic [31:0] crcInputWord;
		logic [31:0] crcResult;
		logic runWhileHalted;
		logic [5:0] memoryPrioritySettings;
		dcq_feed_type feed;
		logic [1:0] feedCount;
		logic [31:0] readData;
		logic readError;
	} dcq_state_type;

endpackage

// [hw/dcq_crc_step.sv]
// Combinational CRC update over one to four little-endian bytes
`timescale 1ns/1ns
`default_nettype none
`include "dcq_params.svh"

module dcq_crc_step (
	// Running value and data
	input wire logic [31:0] crcIn,
	input wire logic [31:0] dataIn,
	input wire logic [2:0] byteCount,
	input wire logic isCrc32,
	// Updated value
	output logic [31:0] crcOut
);

	// Bit-serial shift, low byte first
	always_comb begin
		logic [31:0] c;
		logic fb;
		logic inBit;
		int nBits;
		c = crcIn;
		fb = 1'b0;
		inBit = 1'b0;
		nBits = 8 * int'(byteCount);
		for (int i = 0; i < 32; i++) begin
			if (i < nBits) begin
				// Reflected input for 32-bit, MSB first per byte for 16-bit
				if (isCrc32) begin
					inBit = dataIn[i];
					fb = c[31] ^ inBit;
					c = {c[30:0], 1'b0} ^ (fb ? `DCQ_GEN32 : 32'h00000000);
				end else begin
					inBit = dataIn[(i / 8) * 8 + 7 - (i % 8)];
					fb = c[15] ^ inBit;
					c = {16'h0000, c[14:0], 1'b0}
						^ {16'h0000, (fb ? `DCQ_GEN16 : 16'h0000)};
				end
			end
		end
		crcOut = c;
	end

endmodule
`default_nettype wire

// [hw/dcq_crc_unit.sv]
// Checksum unit with debug-halt and memory priority control, APB slave
//
// Operation
// - A word written to the input register is the data being checksummed.
// - New checksum is ready beat-size code plus one cycles after input write.
// - Checksum resets to zero; software may preset it while unit is off.
// - Checksum register writes are accepted only while the unit is off.
// - CRC-32 and not busy: checksum reads bit-reversed and complemented.
// - CRC-16 or busy: checksum reads raw contents.
// - Under CRC-16 the upper half of the checksum reads zero.
// - Zero flag clears whenever a new input source is selected.
// - Zero flag sets when a run completes with a zero checksum.
// - CRC-32 residue is fixed constant; complemented appendix gives zero.
// - In I/O mode software writes one to busy to end the run.
// - With a channel source and the unit on, busy follows that channel's enable.
// - With a channel source, software writes to busy are ignored.
// - Busy sets on I/O source selection and stays while source uses unit.
// - Run-while-halted bit survives soft reset, cleared by system reset.
// - Bit low: controller stalls under debug halt; high: keeps running.
// - Bits 5:4 give priority signalled for data transfers.
// - Bits 3:2 give priority signalled for descriptor fetches.
// - Bits 1:0 give priority signalled for write-back.
// - Priority codes: background, bandwidth, latency, critical latency.
// - Priority register resets to 0x2A, all fields latency-sensitive.
// - Polynomial code 0 is CRC-16 CCITT, code 1 is CRC-32.
// - Beat code 0 byte, 1 halfword, 2 word; 3 reserved.
// - Source code: none, I/O, or channel 0x20 plus n; locked while busy.
// - Disable takes effect only when busy clear; writing one enables.
`timescale 1ns/1ns
`default_nettype none
`include "dcq_params.svh"

module dcq_crc_unit (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// APB slave
	input wire dcq_pkg::dcq_apb_req_type apbReq,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Transfer engine link
	input wire logic [31:0] channelEnable,
	input wire dcq_pkg::dcq_beat_type channelBeat,
	// Debug
	input wire logic cpuHalted,
	output logic controllerStall,
	// Memory priority
	output dcq_pkg::dcq_qos_type memoryPriority
);
	import dcq_pkg::*;

	// ****************************************
	// State and decode
	// ****************************************

	dcq_state_type s_reg;
	dcq_state_type s_next;
	logic setupPhase;
	logic accessWrite;
	logic [7:0] regIndex;
	logic [31:0] wdata;
	logic isChanSrc;
	logic isIoSrc;
	logic [4:0] chanNum;
	logic chanEnabled;
	logic [31:0] reversedResult;
	logic [31:0] visibleResult;
	logic [31:0] stepIn;
	logic [2:0] stepBytes;
	logic [31:0] stepOut;
	logic [31:0] nextVisible;

	// Bus phases
	assign setupPhase = apbReq.psel & ~apbReq.penable;
	assign accessWrite = apbReq.psel & apbReq.penable & apbReq.pwrite;
	assign regIndex = apbReq.paddr[9:2];
	assign wdata = apbReq.pwdata;

	// Source decode
	// Reserved source codes select no path and feed nothing
	assign isIoSrc = s_reg.checksumSourceSelect == `DCQ_SRC_IO;
	assign isChanSrc = s_reg.checksumSourceSelect[5];
	assign chanNum = s_reg.checksumSourceSelect[4:0];
	assign chanEnabled = channelEnable[chanNum];

	// Debug halt stall
	assign controllerStall = cpuHalted & ~s_reg.runWhileHalted;

	// ****************************************
	// Checksum views
	// ****************************************

	// Bit reversal of the stored checksum
	// Pure wiring, so the read path gains no logic depth
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : gRev
			assign reversedResult[gi] = s_reg.crcResult[31 - gi];
		end
	endgenerate

	// Software view of the checksum
	// Reserved polynomial codes read as CRC-16
	always_comb begin
		if (s_reg.polynomialSelect != `DCQ_POLY_CRC32) begin
			visibleResult = {16'h0000, s_reg.crcResult[15:0]};
		end else if (s_reg.checksumInProgress) begin
			visibleResult = s_reg.crcResult;
		end else begin
			visibleResult = ~reversedResult;
		end
	end

	// Stored value after completion, used for the zero flag
	// Complemented checksum appended under CRC-32 leaves zero here
	always_comb begin
		if (s_next.polynomialSelect == `DCQ_POLY_CRC32) begin
			nextVisible = s_next.crcResult;
		end else begin
			nextVisible = {16'h0000, s_next.crcResult[15:0]};
		end
	end

	// ****************************************
	// CRC step
	// ****************************************

	// Operand: channel beat or held input word
	always_comb begin
		if (isChanSrc) begin
			stepIn = channelBeat.data;
			stepBytes = beatBytes(channelBeat.beatCode);
		end else begin
			stepIn = s_reg.crcInputWord;
			stepBytes = beatBytes(s_reg.beatSizeCode);
		end
	end

	// Bytes in a beat; reserved code treated as word
	function automatic logic [2:0] beatBytes(input logic [1:0] code);
		case (code)
			`DCQ_BEAT_BYTE: beatBytes = 3'h1;
			`DCQ_BEAT_HWORD: beatBytes = 3'h2;
			default: beatBytes = 3'h4;
		endcase
	endfunction

	// Whole beat folded in one clock
	dcq_crc_step uStep (
		.crcIn(s_reg.crcResult),
		.dataIn(stepIn),
		.byteCount(stepBytes),
		.isCrc32(s_reg.polynomialSelect == `DCQ_POLY_CRC32),
		.crcOut(stepOut)
	);

	// ****************************************
	// Next state
	// ****************************************

	always_comb begin
		s_next = s_reg;

		// Setup phase: capture read data and error
		if (setupPhase) begin
			s_next.readError = 1'b0;
			case (regIndex)
				`DCQ_IDX_CTRL: begin
					s_next.readData = 32'h00000000;
					s_next.readData[`DCQ_CTRL_ON] = s_reg.checksumUnitOn;
					s_next.readError = apbReq.pwrite
						& wdata[`DCQ_CTRL_SWRST] & s_reg.checksumUnitOn;
				end
				`DCQ_IDX_CRCCTRL: begin
					s_next.readData = 32'h00000000;
					s_next.readData[`DCQ_CC_SRC_LSB +: 6] =
						s_reg.checksumSourceSelect;
					s_next.readData[`DCQ_CC_POLY_LSB +: 2] =
						s_reg.polynomialSelect;
					s_next.readData[`DCQ_CC_BEAT_LSB +: 2] =
						s_reg.beatSizeCode;
				end
				`DCQ_IDX_DATAIN: s_next.readData = s_reg.crcInputWord;
				`DCQ_IDX_CHKSUM: s_next.readData = visibleResult;
				`DCQ_IDX_STATUS: begin
					s_next.readData = 32'h00000000;
					s_next.readData[`DCQ_ST_BUSY] = s_reg.checksumInProgress;
					s_next.readData[`DCQ_ST_ZERO] = s_reg.resultIsZeroFlag;
				end
				`DCQ_IDX_DBG: begin
					s_next.readData = 32'h00000000;
					s_next.readData[`DCQ_DBG_RUN] = s_reg.runWhileHalted;
				end
				`DCQ_IDX_QOS: begin
					s_next.readData = {26'h0000000, s_reg.memoryPrioritySettings};
				end
				default: begin
					s_next.readData = 32'h00000000;
					s_next.readError = 1'b1;
				end
			endcase
		end

		// Input feed, halted with the controller under debug
		// A halted feed resumes where it stopped
		if (s_reg.checksumUnitOn && !controllerStall) begin
			if (isChanSrc) begin
				if (channelBeat.valid && channelBeat.channel == chanNum
					&& chanEnabled) begin
					s_next.crcResult = stepOut;
				end
			end else begin
				case (s_reg.feed)
					FEED_IDLE: s_next.feed = FEED_IDLE;
					FEED_WAIT: begin
						if (s_reg.feedCount == 2'h0) begin
							s_next.crcResult = stepOut;
							s_next.feed = FEED_IDLE;
						end else begin
							s_next.feedCount = s_reg.feedCount - 2'h1;
						end
					end
					default: s_next.feed = FEED_IDLE;
				endcase
			end
		end

		// Channel source: busy tracks the channel enable
		// Enable sampled here, so busy lags it by one clock
		if (isChanSrc && s_reg.checksumUnitOn) begin
			s_next.checksumInProgress = chanEnabled;
		end

		// Register writes in the access phase
		if (accessWrite) begin
			case (regIndex)
				`DCQ_IDX_CTRL: begin
					if (wdata[`DCQ_CTRL_ON]) begin
						s_next.checksumUnitOn = 1'b1;
					end else if (!s_reg.checksumInProgress) begin
						s_next.checksumUnitOn = 1'b0;
						s_next.feed = FEED_IDLE; // Pending word dropped
					end
				end
				`DCQ_IDX_CRCCTRL: begin
					if (!s_reg.checksumInProgress) begin
						s_next.checksumSourceSelect = wdata[`DCQ_CC_SRC_LSB +: 6];
						s_next.polynomialSelect = wdata[`DCQ_CC_POLY_LSB +: 2];
						s_next.beatSizeCode = wdata[`DCQ_CC_BEAT_LSB +: 2];
						s_next.resultIsZeroFlag = 1'b0;
						if (wdata[`DCQ_CC_SRC_LSB +: 6] == `DCQ_SRC_IO) begin
							s_next.checksumInProgress = 1'b1;
						end
					end
				end
				`DCQ_IDX_DATAIN: begin
					s_next.crcInputWord = wdata;
					// Held while off but never fed
					if (isIoSrc && s_reg.checksumUnitOn) begin
						s_next.feed = FEED_WAIT;
						s_next.feedCount = s_reg.beatSizeCode;
					end
				end
				`DCQ_IDX_CHKSUM: begin
					if (!s_reg.checksumUnitOn) begin
						s_next.crcResult = wdata;
					end
				end
				`DCQ_IDX_STATUS: begin
					if (wdata[`DCQ_ST_BUSY] && !isChanSrc) begin
						s_next.checksumInProgress = 1'b0;
					end
				end
				`DCQ_IDX_DBG: s_next.runWhileHalted = wdata[`DCQ_DBG_RUN];
				`DCQ_IDX_QOS: s_next.memoryPrioritySettings = wdata[5:0];
				default: s_next.readError = s_reg.readError;
			endcase
		end

		// Run completion: busy falls, test the finished checksum
		// Clears need busy low, so a set never meets a clear
		if (s_reg.checksumInProgress && !s_next.checksumInProgress) begin
			if (nextVisible == 32'h00000000) begin
				s_next.resultIsZeroFlag = 1'b1;
			end
		end

		// Soft reset while unit is off keeps the debug bit
		// Last in the process so it overrides every write above
		if (accessWrite && regIndex == `DCQ_IDX_CTRL
			&& wdata[`DCQ_CTRL_SWRST] && !s_reg.checksumUnitOn) begin
			s_next = resetState(s_reg.runWhileHalted);
		end
	end

	// Reset image of the state
	// Shared with soft reset, which passes the debug bit in
	function automatic dcq_state_type resetState(input logic keepRun);
		dcq_state_type r;
		r = '0;
		r.crcResult = `DCQ_RST_CHKSUM;
		r.memoryPrioritySettings = `DCQ_RST_QOS;
		r.runWhileHalted = keepRun;
		r.feed = FEED_IDLE;
		resetState = r;
	endfunction

	// ****************************************
	// State register
	// ****************************************

	// System reset loads the reset image, priority 0x2A, debug bit cleared
	always_ff @(posedge clock) begin
		if (!rstn) begin
			s_reg <= resetState(1'b0);
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************

	// No wait states: data captured in setup, answered in access
	// Read data frozen at setup, so same-cycle updates cannot tear it
	assign pready = apbReq.psel & apbReq.penable;
	assign prdata = s_reg.readData;
	assign pslverr = s_reg.readError;

	// Priority fields straight from the register
	assign memoryPriority.transferPriority =
		s_reg.memoryPrioritySettings[`DCQ_QOS_XFER_LSB +: 2];
	assign memoryPriority.fetchPriority =
		s_reg.memoryPrioritySettings[`DCQ_QOS_FETCH_LSB +: 2];
	assign memoryPriority.writebackPriority =
		s_reg.memoryPrioritySettings[`DCQ_QOS_WRB_LSB +: 2];

endmodule
`default_nettype wire

// [test/dcq_crc_unit_assertions.sv]
// Port-level assertions for the checksum unit
`timescale 1ns/1ns
`default_nettype none
`include "dcq_params.svh"
module dcq_crc_unit_assertions (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Watched ports
	input wire dcq_pkg::dcq_apb_req_type apbReq,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpuHalted,
	input wire logic controllerStall,
	input wire dcq_pkg::dcq_qos_type memoryPriority
);
	import dcq_pkg::*;
	// ****
	// Helpers
	// ****
	logic acc;
	logic qosWr;
	logic ctrlWr;
	logic runSeen;
	// Write access decode
	assign acc = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign qosWr = acc && apbReq.paddr[9:2] == `DCQ_IDX_QOS;
	assign ctrlWr = acc && apbReq.paddr[9:2] == `DCQ_IDX_CTRL;
	// Last written run bit, cleared by system reset only
	always_ff @(posedge clock) begin
		if (!rstn) begin
			runSeen <= 1'b0;
		end else if (acc && apbReq.paddr[9:2] == `DCQ_IDX_DBG) begin
			runSeen <= apbReq.pwdata[0];
		end
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	property p_ready;
		pready == (apbReq.psel && apbReq.penable);
	endproperty
	a_ready: assert property (p_ready) else $error("pready wrong");
	property p_qos_rst;
		$rose(rstn) |-> memoryPriority == `DCQ_RST_QOS;
	endproperty
	a_qos_rst: assert property (p_qos_rst) else $error("qos reset");
	property p_qos_wr;
		qosWr |=> memoryPriority == $past(apbReq.pwdata[5:0]);
	endproperty
	a_qos_wr: assert property (p_qos_wr) else $error("qos write");
	property p_qos_hold;
		!qosWr && !ctrlWr |=> $stable(memoryPriority);
	endproperty
	a_qos_hold: assert property (p_qos_hold) else $error("qos moved");
	property p_soft;
		ctrlWr && apbReq.pwdata[0] && !pslverr |=> memoryPriority == 6'h2a;
	endproperty
	a_soft: assert property (p_soft) else $error("qos soft reset");
	property p_free;
		!cpuHalted |-> !controllerStall;
	endproperty
	a_free: assert property (p_free) else $error("stall unhalted");
	property p_halt;
		cpuHalted && !runSeen |-> controllerStall;
	endproperty
	a_halt: assert property (p_halt) else $error("no stall");
	property p_run;
		runSeen |-> !controllerStall;
	endproperty
	a_run: assert property (p_run) else $error("stall in run");
	// Main scenarios
	c_qos: cover property (qosWr);
	c_stall: cover property (cpuHalted && controllerStall);
	c_soft: cover property (ctrlWr && apbReq.pwdata[0] && !pslverr);
endmodule
bind dcq_crc_unit dcq_crc_unit_assertions i_chk (
	.clock(clock), .rstn(rstn), .apbReq(apbReq), .pready(pready),
	.pslverr(pslverr), .cpuHalted(cpuHalted),
	.controllerStall(controllerStall), .memoryPriority(memoryPriority)
);
`default_nettype wire

// [test/dcq_chan_model.sv]
// Behavioural transfer-engine channels feeding the checksum unit
`timescale 1ns/1ns
`default_nettype none
module dcq_chan_model (
	// Clock
	input wire logic clock,
	// Channel link
	output logic [31:0] channelEnable,
	output dcq_pkg::dcq_beat_type channelBeat
);
	import dcq_pkg::*;
	// ****
	// Channel driver
	// ****
	// Idle link at time zero
	initial begin
		channelEnable = 32'h0;
		channelBeat = '{1'b0, 5'h0, 2'h0, 32'h5a5a5a5a};
	end
	// Raise or drop one channel enable
	task automatic setEnable(input logic [4:0] ch, input logic on);
		channelEnable[ch] <= on;
		@(posedge clock);
	endtask
	// One beat; data line scrambled once released
	task automatic sendBeat(input logic [4:0] ch, input logic [1:0] code,
		input logic [31:0] d);
		channelBeat <= '{1'b1, ch, code, d};
		@(posedge clock);
		channelBeat.valid <= 1'b0;
		channelBeat.data <= ~d;
		@(posedge clock);
	endtask
endmodule
`default_nettype wire

// [test/tb_dma_crc_unit_with_qos_control.sv]
// Self-checking bench for the checksum unit
`timescale 1ns/1ns
`default_nettype none
`include "dcq_params.svh"
module tb_dma_crc_unit_with_qos_control;
	import dcq_pkg::*;
	// ****
	// Harness
	// ****
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic cpuHalted = 1'b0;
	dcq_apb_req_type req = '0;
	logic pready, pslverr, controllerStall, lastErr;
	logic [31:0] prdata, channelEnable, rd, r1;
	dcq_beat_type channelBeat;
	dcq_qos_type memoryPriority;
	int errors = 0;
	int checked = 0;
	// Clock at 100 ns
	always #50 clock = ~clock;
	dcq_crc_unit i_dut (.clock(clock), .rstn(rstn), .apbReq(req),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.channelEnable(channelEnable), .channelBeat(channelBeat),
		.cpuHalted(cpuHalted), .controllerStall(controllerStall),
		.memoryPriority(memoryPriority));
	dcq_chan_model i_chan (.clock(clock), .channelEnable(channelEnable),
		.channelBeat(channelBeat));
	// Reflected CRC-32 over n data bits, low bit first
	function automatic logic [31:0] c32(input logic [31:0] r,
		input logic [31:0] d, input int n);
		for (int i = 0; i < n; i++) begin
			r = (r[0] ^ d[i]) ? (r >> 1) ^ 32'hedb88320 : r >> 1;
		end
		return r;
	endfunction
	// CCITT CRC-16 over one byte, high bit first
	function automatic logic [15:0] c16(input logic [15:0] r,
		input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? (r << 1) ^ `DCQ_GEN16 : r << 1;
		end
		return r;
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] idx,
		input logic [31:0] wd);
		req <= '{1'b1, 1'b0, w, {idx, 2'b00}, wd};
		@(posedge clock);
		req.penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		lastErr = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic chk(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		cmp(rd, exp);
	endtask
	task automatic report_and_stop;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset;
		chk(`DCQ_IDX_QOS, 32'h2a);
		chk(`DCQ_IDX_CHKSUM, 32'h0);
		chk(`DCQ_IDX_STATUS, 32'h0);
		cmp(32'(memoryPriority), 32'h2a);
	endtask
	task automatic t_debug;
		cpuHalted <= 1'b1;
		@(posedge clock);
		cmp(32'(controllerStall), 32'h1);
		wr(`DCQ_IDX_DBG, 32'h1);
		cmp(32'(controllerStall), 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(`DCQ_IDX_QOS, 32'(c * 21));
			cmp(32'(memoryPriority), 32'(c * 21));
		end
		wr(`DCQ_IDX_CTRL, 32'h1);
		chk(`DCQ_IDX_DBG, 32'h1);
		chk(`DCQ_IDX_QOS, 32'h2a);
		apb(1'b0, 8'h01, 32'h0);
		cmp(32'(lastErr), 32'h1);
		cpuHalted <= 1'b0;
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		chk(`DCQ_IDX_DBG, 32'h0);
	endtask
	task automatic t_crc16;
		wr(`DCQ_IDX_CHKSUM, 32'hffff1234);
		chk(`DCQ_IDX_CHKSUM, 32'h1234);
		wr(`DCQ_IDX_CTRL, 32'h4);
		wr(`DCQ_IDX_CHKSUM, 32'h0);
		chk(`DCQ_IDX_CHKSUM, 32'h1234);
		wr(`DCQ_IDX_CTRL, 32'h0);
		wr(`DCQ_IDX_CHKSUM, 32'h0);
		wr(`DCQ_IDX_CRCCTRL, 32'h100);
		chk(`DCQ_IDX_STATUS, 32'h1);
		wr(`DCQ_IDX_CRCCTRL, 32'h0);
		chk(`DCQ_IDX_CRCCTRL, 32'h100);
		wr(`DCQ_IDX_CTRL, 32'h4);
		wr(`DCQ_IDX_CTRL, 32'h0);
		wr(`DCQ_IDX_CHKSUM, 32'h5555);
		chk(`DCQ_IDX_CHKSUM, 32'h0);
		wr(`DCQ_IDX_DATAIN, 32'h0000a531);
		r1 = 32'(c16(16'h0000, 8'h31));
		chk(`DCQ_IDX_CHKSUM, r1);
		wr(`DCQ_IDX_DATAIN, 32'(r1[15:8]));
		wr(`DCQ_IDX_DATAIN, 32'(r1[7:0]));
		repeat (2) @(posedge clock);
		wr(`DCQ_IDX_STATUS, 32'h1);
		chk(`DCQ_IDX_STATUS, 32'h2);
		wr(`DCQ_IDX_CRCCTRL, 32'h100);
		chk(`DCQ_IDX_STATUS, 32'h1);
		wr(`DCQ_IDX_STATUS, 32'h1);
		wr(`DCQ_IDX_CTRL, 32'h0);
	endtask
	task automatic t_crc32;
		r1 = c32(32'hffffffff, 32'h3141_5926, 32);
		wr(`DCQ_IDX_CHKSUM, 32'hffffffff);
		wr(`DCQ_IDX_CRCCTRL, 32'h106);
		wr(`DCQ_IDX_CTRL, 32'h4);
		wr(`DCQ_IDX_DATAIN, 32'h3141_5926);
		chk(`DCQ_IDX_CHKSUM, 32'hffffffff);
		repeat (3) @(posedge clock);
		chk(`DCQ_IDX_CHKSUM, {<<{r1}});
		wr(`DCQ_IDX_DATAIN, ~r1);
		repeat (4) @(posedge clock);
		wr(`DCQ_IDX_STATUS, 32'h1);
		chk(`DCQ_IDX_STATUS, 32'h0);
		chk(`DCQ_IDX_CHKSUM, 32'h2144df1c);
		wr(`DCQ_IDX_CTRL, 32'h0);
		// Same packet closed by the complemented checksum
		wr(`DCQ_IDX_CHKSUM, 32'hffffffff);
		wr(`DCQ_IDX_CRCCTRL, 32'h106);
		wr(`DCQ_IDX_CTRL, 32'h4);
		wr(`DCQ_IDX_DATAIN, 32'h3141_5926);
		repeat (2) @(posedge clock);
		wr(`DCQ_IDX_DATAIN, r1);
		repeat (3) @(posedge clock);
		chk(`DCQ_IDX_CHKSUM, 32'h0);
		wr(`DCQ_IDX_STATUS, 32'h1);
		chk(`DCQ_IDX_STATUS, 32'h2);
		wr(`DCQ_IDX_CTRL, 32'h0);
	endtask
	task automatic t_chan;
		wr(`DCQ_IDX_CHKSUM, 32'hffffffff);
		wr(`DCQ_IDX_CRCCTRL, 32'h2304);
		wr(`DCQ_IDX_CTRL, 32'h4);
		i_chan.setEnable(5'd3, 1'b1);
		@(posedge clock);
		chk(`DCQ_IDX_STATUS, 32'h1);
		wr(`DCQ_IDX_STATUS, 32'h1);
		chk(`DCQ_IDX_STATUS, 32'h1);
		i_chan.sendBeat(5'd5, 2'h2, 32'hdeadbeef);
		i_chan.sendBeat(5'd3, 2'h1, 32'h1234_abcd);
		i_chan.setEnable(5'd3, 1'b0);
		@(posedge clock);
		chk(`DCQ_IDX_STATUS, 32'h0);
		r1 = c32(32'hffffffff, 32'h1234_abcd, 16);
		chk(`DCQ_IDX_CHKSUM, ~r1);
		wr(`DCQ_IDX_CTRL, 32'h0);
	endtask
	// Watchdog
	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		t_reset;
		t_debug;
		t_crc16;
		t_crc32;
		t_chan;
		report_and_stop;
	end
endmodule
`default_nettype wire
